// [rtl/gtu_timer.sv]
// Purpose: Two 16-bit timers that chain into one 32-bit timer or clock.
// Assumes: Register writes are one-cycle strobes on clk_in; pin is asynchronous.
// Notes: Input capture, edge timing and waveform modes are not provided.
`timescale 1ns/1ns

// Notes on behaviour
// - Config 0 chained timer, 1 chained clock.
// - Config 4 splits into two 16-bit timers.
// - Reset: inactive, counts and loads all ones.
// - Wide load write fills both load halves.
// - Wide count read gives B over A.
// - Chained timer uses only A mode field.
// - Counts down, reloads cycle after zero.
// - One-shot stops and clears enable; periodic continues.
// - Zero sets sticky raw, masked, interrupt.
// - Trigger pulse only when trigger enable set.
// - Load write while running loads counter next.
// - Stall bit holds count until released.
// - Clock mode counts up, first load one.
// - External 32768 Hz pin divided to 1 Hz.
// - Match rolls count to zero, continues.
// - Match sets raw, masked; clear bit clears.
// - Override bit defeats stall in clock mode.
// - Split timers use own mode, prescaler.
// - Split reload restores load and prescale.
// - Split timers run independently together.
// - Prescale p gives p+1 clocks per step.
module gtu_timer
    import gtu_pkg::*;
#(
    parameter int RTC_DIV = GTU_RTC_DIV
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Configuration write.
    input wire logic cfg_wr_in,
    input wire logic [2:0] cfg_data_in,
    // Mode field writes.
    input wire logic mode_a_wr_in,
    input wire logic [1:0] mode_a_data_in,
    input wire logic mode_b_wr_in,
    input wire logic [1:0] mode_b_data_in,
    // Control write.
    input wire logic ctl_wr_in,
    input wire logic ctl_a_enable_in,
    input wire logic ctl_b_enable_in,
    input wire logic ctl_a_stall_in,
    input wire logic ctl_b_stall_in,
    input wire logic ctl_a_trigger_en_in,
    input wire logic ctl_b_trigger_en_in,
    input wire logic ctl_stall_override_in,
    // Interval load, prescale and match writes.
    input wire logic load_a_wr_in,
    input wire logic [31:0] load_a_data_in,
    input wire logic load_b_wr_in,
    input wire logic [15:0] load_b_data_in,
    input wire logic prescale_a_wr_in,
    input wire logic [7:0] prescale_a_data_in,
    input wire logic prescale_b_wr_in,
    input wire logic [7:0] prescale_b_data_in,
    input wire logic match_wr_in,
    input wire logic [31:0] match_data_in,
    // Interrupt mask levels and clear strobe.
    input wire logic mask_a_timeout_in,
    input wire logic mask_b_timeout_in,
    input wire logic mask_clock_match_in,
    input wire logic clear_wr_in,
    input wire logic clear_a_timeout_in,
    input wire logic clear_b_timeout_in,
    input wire logic clear_clock_match_in,
    // Real-time clock pin.
    input wire logic capture_pin_0_in,
    // Count and load readback.
    output logic [31:0] count_a_out,
    output logic [15:0] count_b_out,
    output logic [31:0] load_a_out,
    // Control and status readback.
    output logic a_enable_out,
    output logic b_enable_out,
    output logic a_timeout_raw_out,
    output logic b_timeout_raw_out,
    output logic clock_match_raw_out,
    output logic a_timeout_masked_out,
    output logic b_timeout_masked_out,
    output logic clock_match_masked_out,
    output logic irq_out,
    // Trigger pulses.
    output logic a_trigger_out,
    output logic b_trigger_out
);

    function automatic logic mode_counts(input logic [1:0] mode);
        mode_counts = (mode == GTU_MODE_ONE_SHOT) || (mode == GTU_MODE_PERIODIC);
    endfunction

    function automatic logic mode_periodic(input logic [1:0] mode);
        mode_periodic = (mode == GTU_MODE_PERIODIC);
    endfunction

    logic [2:0] cfg_q;
    logic [1:0] mode_q [2];
    logic en_q [2];
    logic stall_q [2];
    logic trig_en_q [2];
    logic override_q;
    logic rtc_seen_q;
    logic [15:0] cnt_q [2];
    logic [15:0] cnt_d [2];
    logic [15:0] load_q [2];
    logic [7:0] pre_q [2];
    logic [7:0] ps_q [2];
    logic [7:0] ps_d [2];
    logic [31:0] match_q;
    logic timeout [2];
    logic hw_clear_en [2];
    logic clock_hit;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic [31:0] div_q;
    logic rtc_tick;
    logic raw_a_d;
    logic raw_b_d;
    logic raw_m_d;
    logic raw_a_q;
    logic raw_b_q;
    logic raw_m_q;

    wire logic is_32 = (cfg_q == GTU_CFG_32_TIMER);
    wire logic is_rtc = (cfg_q == GTU_CFG_32_RTC);
    wire logic is_16 = (cfg_q == GTU_CFG_16_SPLIT);
    wire logic [31:0] full_cnt = {cnt_q[1], cnt_q[0]};
    wire logic [31:0] full_load = {load_q[1], load_q[0]};
    wire logic rtc_run = is_rtc && en_q[0];

    // Configuration and mode fields.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_q <= GTU_CFG_RESET;
            mode_q[0] <= GTU_MODE_RESET;
            mode_q[1] <= GTU_MODE_RESET;
            rtc_seen_q <= 1'b0;
        end else begin
            if (cfg_wr_in) begin
                cfg_q <= cfg_data_in;
            end
            if (cfg_wr_in && cfg_data_in == GTU_CFG_32_RTC) begin
                rtc_seen_q <= 1'b1;
            end
            if (mode_a_wr_in) begin
                mode_q[0] <= mode_a_data_in;
            end
            if (mode_b_wr_in) begin
                mode_q[1] <= mode_b_data_in;
            end
        end
    end

    // Control bits; a software write beats the one-shot self clear.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_q[0] <= 1'b0;
            en_q[1] <= 1'b0;
            stall_q[0] <= 1'b0;
            stall_q[1] <= 1'b0;
            trig_en_q[0] <= 1'b0;
            trig_en_q[1] <= 1'b0;
            override_q <= 1'b0;
        end else if (ctl_wr_in) begin
            en_q[0] <= ctl_a_enable_in;
            en_q[1] <= ctl_b_enable_in;
            stall_q[0] <= ctl_a_stall_in;
            stall_q[1] <= ctl_b_stall_in;
            trig_en_q[0] <= ctl_a_trigger_en_in;
            trig_en_q[1] <= ctl_b_trigger_en_in;
            override_q <= ctl_stall_override_in;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (hw_clear_en[i]) begin
                    en_q[i] <= 1'b0;
                end
            end
        end
    end

    // Load, prescale and match registers.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            load_q[0] <= GTU_LOAD_RESET;
            load_q[1] <= GTU_LOAD_RESET;
            pre_q[0] <= GTU_PRESCALE_RESET;
            pre_q[1] <= GTU_PRESCALE_RESET;
            match_q <= GTU_MATCH_RESET;
        end else begin
            if (load_a_wr_in) begin
                load_q[0] <= load_a_data_in[15:0];
            end
            if (load_a_wr_in && !is_16) begin
                load_q[1] <= load_a_data_in[31:16];
            end else if (load_b_wr_in) begin
                load_q[1] <= load_b_data_in;
            end
            if (prescale_a_wr_in) begin
                pre_q[0] <= prescale_a_data_in;
            end
            if (prescale_b_wr_in) begin
                pre_q[1] <= prescale_b_data_in;
            end
            if (match_wr_in) begin
                match_q <= match_data_in;
            end
        end
    end

    // The pin is synchronised before any edge logic sees it.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= capture_pin_0_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Divider restarts whenever the clock is disabled or left, so each enable gives a full second; stall does not restart it.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_q <= 32'h00000000;
        end else if (!rtc_run) begin
            div_q <= 32'h00000000;
        end else if (pin_s2_q && !pin_s3_q) begin
            if (rtc_tick) begin
                div_q <= 32'h00000000;
            end else begin
                div_q <= div_q + 32'h00000001;
            end
        end
    end

    assign rtc_tick = rtc_run && pin_s2_q && !pin_s3_q
        && (div_q == 32'(RTC_DIV - 1));

    // Next count for every configuration.
    always_comb begin
        logic [31:0] wide;
        wide = full_cnt;
        cnt_d[0] = cnt_q[0];
        cnt_d[1] = cnt_q[1];
        ps_d[0] = ps_q[0];
        ps_d[1] = ps_q[1];
        timeout[0] = 1'b0;
        timeout[1] = 1'b0;
        hw_clear_en[0] = 1'b0;
        hw_clear_en[1] = 1'b0;
        clock_hit = 1'b0;
        if (is_32) begin
            if (en_q[0] && mode_counts(mode_q[0]) && !stall_q[0]) begin
                if (full_cnt == 32'h00000000) begin
                    wide = full_load;
                    timeout[0] = 1'b1;
                    hw_clear_en[0] = !mode_periodic(mode_q[0]);
                end else begin
                    wide = full_cnt - 32'h00000001;
                end
            end
            if (load_a_wr_in) begin
                wide = load_a_data_in;
            end
            cnt_d[0] = wide[15:0];
            cnt_d[1] = wide[31:16];
        end else if (is_rtc) begin
            if (rtc_tick && (!(stall_q[0] || stall_q[1]) || override_q)) begin
                if (full_cnt == match_q) begin
                    wide = GTU_RTC_ROLL_VALUE;
                    clock_hit = 1'b1;
                end else begin
                    wide = full_cnt + 32'h00000001;
                end
            end
            cnt_d[0] = wide[15:0];
            cnt_d[1] = wide[31:16];
        end else if (is_16) begin
            for (int i = 0; i < 2; i++) begin
                if (en_q[i] && mode_counts(mode_q[i]) && !stall_q[i]) begin
                    if (ps_q[i] != 8'h00) begin
                        ps_d[i] = ps_q[i] - 8'h01;
                    end else if (cnt_q[i] == 16'h0000) begin
                        cnt_d[i] = load_q[i];
                        ps_d[i] = pre_q[i];
                        timeout[i] = 1'b1;
                        hw_clear_en[i] = !mode_periodic(mode_q[i]);
                    end else begin
                        cnt_d[i] = cnt_q[i] - 16'h0001;
                        ps_d[i] = pre_q[i];
                    end
                end
            end
            if (load_a_wr_in) begin
                cnt_d[0] = load_a_data_in[15:0];
            end
            if (load_b_wr_in) begin
                cnt_d[1] = load_b_data_in;
            end
        end
        if (cfg_wr_in && cfg_data_in == GTU_CFG_32_RTC && !rtc_seen_q) begin
            cnt_d[0] = GTU_RTC_FIRST_LOAD[15:0];
            cnt_d[1] = GTU_RTC_FIRST_LOAD[31:16];
        end
    end

    // Counters and prescale counters.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q[0] <= GTU_CNT_RESET;
            cnt_q[1] <= GTU_CNT_RESET;
            ps_q[0] <= GTU_PRESCALE_RESET;
            ps_q[1] <= GTU_PRESCALE_RESET;
        end else begin
            cnt_q[0] <= cnt_d[0];
            cnt_q[1] <= cnt_d[1];
            ps_q[0] <= ps_d[0];
            ps_q[1] <= ps_d[1];
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle.
    always_comb begin
        raw_a_d = timeout[0] || (raw_a_q && !(clear_wr_in && clear_a_timeout_in));
        raw_b_d = timeout[1] || (raw_b_q && !(clear_wr_in && clear_b_timeout_in));
        raw_m_d = clock_hit || (raw_m_q && !(clear_wr_in && clear_clock_match_in));
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            raw_a_q <= 1'b0;
            raw_b_q <= 1'b0;
            raw_m_q <= 1'b0;
            a_timeout_masked_out <= 1'b0;
            b_timeout_masked_out <= 1'b0;
            clock_match_masked_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            raw_a_q <= raw_a_d;
            raw_b_q <= raw_b_d;
            raw_m_q <= raw_m_d;
            a_timeout_masked_out <= raw_a_d && mask_a_timeout_in;
            b_timeout_masked_out <= raw_b_d && mask_b_timeout_in;
            clock_match_masked_out <= raw_m_d && mask_clock_match_in;
            irq_out <= (raw_a_d && mask_a_timeout_in) || (raw_b_d && mask_b_timeout_in)
                || (raw_m_d && mask_clock_match_in);
        end
    end

    // Trigger pulses last one cycle per time-out.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            a_trigger_out <= 1'b0;
            b_trigger_out <= 1'b0;
        end else begin
            a_trigger_out <= timeout[0] && trig_en_q[0];
            b_trigger_out <= timeout[1] && trig_en_q[1];
        end
    end

    // Readback registers show the values of the previous cycle's state.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_a_out <= {16'h0000, GTU_CNT_RESET};
            count_b_out <= GTU_CNT_RESET;
            load_a_out <= {16'h0000, GTU_LOAD_RESET};
            a_enable_out <= 1'b0;
            b_enable_out <= 1'b0;
            a_timeout_raw_out <= 1'b0;
            b_timeout_raw_out <= 1'b0;
            clock_match_raw_out <= 1'b0;
        end else begin
            if (is_16) begin
                count_a_out <= {16'h0000, cnt_q[0]};
                load_a_out <= {16'h0000, load_q[0]};
            end else begin
                count_a_out <= full_cnt;
                load_a_out <= full_load;
            end
            count_b_out <= cnt_q[1];
            a_enable_out <= en_q[0];
            b_enable_out <= en_q[1];
            a_timeout_raw_out <= raw_a_q;
            b_timeout_raw_out <= raw_b_q;
            clock_match_raw_out <= raw_m_q;
        end
    end

endmodule

// [rtl/gtu_pkg.sv]
// Purpose: Shared constants for the general timer unit.
// Assumes: One system clock; configuration arrives on plain write ports.
// Notes: Mode field codes follow the one-shot and periodic encodings.
package gtu_pkg;

    // Configuration values.
    localparam logic [2:0] GTU_CFG_32_TIMER = 3'h0;
    localparam logic [2:0] GTU_CFG_32_RTC = 3'h1;
    localparam logic [2:0] GTU_CFG_16_SPLIT = 3'h4;
    localparam logic [2:0] GTU_CFG_RESET = 3'h0;

    // Mode field values.
    localparam logic [1:0] GTU_MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] GTU_MODE_PERIODIC = 2'h2;
    localparam logic [1:0] GTU_MODE_RESET = 2'h0;

    // Reset values of counters, loads and prescalers.
    localparam logic [15:0] GTU_CNT_RESET = 16'hFFFF;
    localparam logic [15:0] GTU_LOAD_RESET = 16'hFFFF;
    localparam logic [7:0] GTU_PRESCALE_RESET = 8'h00;
    localparam logic [31:0] GTU_MATCH_RESET = 32'hFFFFFFFF;

    // Real-time clock values.
    localparam logic [31:0] GTU_RTC_FIRST_LOAD = 32'h00000001;
    localparam logic [31:0] GTU_RTC_ROLL_VALUE = 32'h00000000;

    // Real-time clock input rate and tick rate, in Hz.
    localparam int GTU_RTC_IN_HZ = 32768;
    localparam int GTU_RTC_TICK_HZ = 1;
    localparam int GTU_RTC_DIV = GTU_RTC_IN_HZ / GTU_RTC_TICK_HZ;

endpackage

// [tb/gtu_timer_asserts.sv]
// Purpose: Port-level checks for the general timer unit.
// Assumes: Bound to gtu_timer; one clock domain.
// Notes: Flag checks lean on the one-cycle readback lag of the outputs.
`timescale 1ns/1ns
module gtu_timer_asserts (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Watched inputs.
    input wire logic mask_clock_match_in,
    input wire logic clear_wr_in,
    input wire logic clear_a_timeout_in,
    // Watched outputs.
    input wire logic [31:0] count_a_out,
    input wire logic [15:0] count_b_out,
    input wire logic [31:0] load_a_out,
    input wire logic a_enable_out,
    input wire logic a_timeout_raw_out,
    input wire logic b_timeout_raw_out,
    input wire logic clock_match_raw_out,
    input wire logic a_timeout_masked_out,
    input wire logic b_timeout_masked_out,
    input wire logic clock_match_masked_out,
    input wire logic irq_out,
    input wire logic a_trigger_out,
    input wire logic b_trigger_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    reset_counts_a: assert property ($rose(rst_b_in) |-> count_a_out == 32'h0000FFFF &&
        count_b_out == 16'hFFFF && load_a_out == 32'h0000FFFF) else $error("Bad reset counts.");
    a_raw_follows_a: assert property (a_trigger_out |=> a_timeout_raw_out)
        else $error("A raw flag missing.");
    b_raw_follows_a: assert property (b_trigger_out |=> b_timeout_raw_out)
        else $error("B raw flag missing.");
    irq_is_or_a: assert property (irq_out == (a_timeout_masked_out ||
        b_timeout_masked_out || clock_match_masked_out)) else $error("Interrupt mismatch.");
    masked_has_raw_a: assert property (a_timeout_masked_out |=> a_timeout_raw_out)
        else $error("Masked flag without raw.");
    clock_mask_a: assert property (clock_match_masked_out |-> $past(mask_clock_match_in))
        else $error("Match flag ignores mask.");
    match_zero_a: assert property ($rose(clock_match_raw_out) |-> count_a_out == 32'h0)
        else $error("Clock did not roll to zero.");
    clear_a_timeout_a: assert property (clear_wr_in && clear_a_timeout_in && !a_enable_out
        ##1 !a_enable_out |=> !a_timeout_raw_out) else $error("Clear ignored.");
    cover property (a_trigger_out);
    cover property (b_trigger_out);
    cover property ($rose(clock_match_raw_out));
endmodule

bind gtu_timer gtu_timer_asserts i_chk (.clk_in, .rst_b_in, .mask_clock_match_in, .clear_wr_in,
    .clear_a_timeout_in, .count_a_out, .count_b_out, .load_a_out, .a_enable_out,
    .a_timeout_raw_out, .b_timeout_raw_out, .clock_match_raw_out, .a_timeout_masked_out,
    .b_timeout_masked_out, .clock_match_masked_out, .irq_out, .a_trigger_out, .b_trigger_out);

// [tb/test_gtu_timer.sv]
// Purpose: Self-checking bench for the general timer unit.
// Assumes: The clock divider is shortened to 4 so clock ticks come quickly.
// Notes: Periods are timed between trigger pulses, which hides readback lag.
`timescale 1ns/1ns
module test_gtu_timer;
    import gtu_pkg::*;
    localparam int DIV = 4;
    localparam int CFG = 0, MDA = 1, MDB = 2, CTL = 3, LDA = 4, LDB = 5, PRA = 6, PRB = 7;
    localparam int MAT = 8, CLR = 9;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic pin = 1'b0;
    logic [9:0] stb = '0;
    logic [2:0] cfg_d = '0, msk = '0, clr = '0;
    logic [1:0] ma = '0, mb = '0;
    logic [6:0] ctl = '0;
    logic [31:0] la = '0, mt = '0, cnt_a, ld_a;
    logic [15:0] lb = '0, cnt_b;
    logic [7:0] pa = '0, pb = '0;
    logic ena, enb, rawa, rawb, rawc, mska, mskb, mskc, irq, trga, trgb;
    int n_errors = 0, n_checks = 0, seed = 28, p, q, ea, eb;
    int exp_q[$];

    gtu_timer #(.RTC_DIV(DIV)) i_dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_wr_in(stb[CFG]), .cfg_data_in(cfg_d),
        .mode_a_wr_in(stb[MDA]), .mode_a_data_in(ma), .mode_b_wr_in(stb[MDB]), .mode_b_data_in(mb),
        .ctl_wr_in(stb[CTL]), .ctl_a_enable_in(ctl[0]), .ctl_b_enable_in(ctl[1]),
        .ctl_a_stall_in(ctl[2]), .ctl_b_stall_in(ctl[3]), .ctl_a_trigger_en_in(ctl[4]),
        .ctl_b_trigger_en_in(ctl[5]), .ctl_stall_override_in(ctl[6]),
        .load_a_wr_in(stb[LDA]), .load_a_data_in(la), .load_b_wr_in(stb[LDB]), .load_b_data_in(lb),
        .prescale_a_wr_in(stb[PRA]), .prescale_a_data_in(pa), .prescale_b_wr_in(stb[PRB]),
        .prescale_b_data_in(pb), .match_wr_in(stb[MAT]), .match_data_in(mt),
        .mask_a_timeout_in(msk[0]), .mask_b_timeout_in(msk[1]), .mask_clock_match_in(msk[2]),
        .clear_wr_in(stb[CLR]), .clear_a_timeout_in(clr[0]), .clear_b_timeout_in(clr[1]),
        .clear_clock_match_in(clr[2]), .capture_pin_0_in(pin), .count_a_out(cnt_a),
        .count_b_out(cnt_b), .load_a_out(ld_a), .a_enable_out(ena), .b_enable_out(enb),
        .a_timeout_raw_out(rawa), .b_timeout_raw_out(rawb), .clock_match_raw_out(rawc),
        .a_timeout_masked_out(mska), .b_timeout_masked_out(mskb), .clock_match_masked_out(mskc),
        .irq_out(irq), .a_trigger_out(trga), .b_trigger_out(trgb));

    always #2 clk_in = ~clk_in;
    // The slow clock runs free; every second toggle lands on a system clock edge.
    always #17 pin = ~pin;

    task automatic wr(input int r, input logic [31:0] v);
        @(negedge clk_in);
        case (r)
            CFG: cfg_d = v[2:0];
            MDA: ma = v[1:0];
            MDB: mb = v[1:0];
            CTL: ctl = v[6:0];
            LDA: la = v;
            LDB: lb = v[15:0];
            PRA: pa = v[7:0];
            PRB: pb = v[7:0];
            MAT: mt = v;
            default: clr = v[2:0];
        endcase
        stb[r] = 1'b1;
        @(negedge clk_in);
        stb = '0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic per(input int b, output int n);
        n = 0;
        while (((b ? trgb : trga) !== 1'b1) && n < 20000) begin
            @(negedge clk_in);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (((b ? trgb : trga) !== 1'b1) && n < 20000);
    endtask

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The tests need under two thousand cycles; the limit allows five times that.
    initial begin
        #40000;
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (16) @(negedge clk_in);
        rst_b_in = 1'b1;
        @(negedge clk_in);
        chk(cnt_a, {GTU_CNT_RESET, GTU_CNT_RESET});
        chk(ld_a, {GTU_LOAD_RESET, GTU_LOAD_RESET});
        chk({cnt_b, trga, trgb, mska, mskb, mskc}, {GTU_CNT_RESET, 5'h00});
        chk({ena, enb, rawa, rawb, rawc, irq}, '0);
        wr(MDB, GTU_MODE_ONE_SHOT);
        wr(MDA, GTU_MODE_PERIODIC);
        wr(LDA, 32'h00010003);
        repeat (2) @(negedge clk_in);
        chk(ld_a, 32'h00010003);
        chk(cnt_b, 16'h0001);
        chk(cnt_a, 32'h00010003);
        msk = 3'b111;
        wr(CTL, 32'h11);
        wr(LDA, 32'h4);
        per(0, p);
        chk(p, 5);
        @(negedge clk_in);
        chk({ena, rawa, mska, irq}, 4'hF);
        wr(LDA, 32'h100);
        wr(CTL, 32'h15);
        repeat (2) @(negedge clk_in);
        ea = cnt_a;
        repeat (20) @(negedge clk_in);
        chk(cnt_a, ea);
        wr(CTL, 32'h11);
        repeat (3) @(negedge clk_in);
        chk(cnt_a < ea, 1'b1);
        wr(CLR, 3'b111);
        wr(MDA, GTU_MODE_ONE_SHOT);
        msk = 3'b000;
        wr(LDA, 32'h6);
        wr(CTL, 32'h01);
        q = 0;
        repeat (30) begin
            @(negedge clk_in);
            q += trga;
        end
        chk(q, 0);
        chk({ena, rawa, mska, irq}, 4'b0100);
        ea = cnt_a;
        repeat (5) @(negedge clk_in);
        chk(cnt_a, ea);
        wr(CLR, 3'b001);
        repeat (2) @(negedge clk_in);
        chk(rawa, 1'b0);
        wr(CFG, GTU_CFG_16_SPLIT);
        wr(MDA, GTU_MODE_PERIODIC);
        wr(MDB, GTU_MODE_PERIODIC);
        for (int i = 0; i < 3; i++) begin
            ea = ($random(seed) & 7) + 1;
            eb = $random(seed) & 7;
            wr(LDA, ea);
            wr(PRA, eb);
            wr(LDB, 3);
            wr(PRB, i);
            wr(CTL, 32'h33);
            exp_q.push_back((ea + 1) * (eb + 1));
            exp_q.push_back(4 * (i + 1));
            fork
                per(0, p);
                per(1, q);
            join
            chk(p, exp_q.pop_front());
            chk(q, exp_q.pop_front());
            chk({cnt_a[31:16], ld_a[31:16]}, '0);
        end
        chk({rawa, rawb, enb, mskb}, 4'hE);
        wr(CTL, 32'h0);
        wr(CLR, 3'b111);
        wr(CFG, GTU_CFG_32_RTC);
        repeat (2) @(negedge clk_in);
        chk(cnt_a, GTU_RTC_FIRST_LOAD);
        wr(MAT, 32'h3);
        msk = 3'b100;
        wr(CTL, 32'h45);
        q = 0;
        while (rawc !== 1'b1 && q < 2000) begin
            @(negedge clk_in);
            q++;
        end
        chk(q > (3 * DIV - 1) * 17 / 2 && q < 3 * DIV * 17 / 2 + 12, 1'b1);
        chk(cnt_a, GTU_RTC_ROLL_VALUE);
        chk({mskc, irq}, 2'b11);
        wr(CLR, 3'b100);
        repeat (2) @(negedge clk_in);
        chk({rawc, mskc, irq}, '0);
        wr(CTL, 32'h05);
        repeat (2) @(negedge clk_in);
        ea = cnt_a;
        repeat (80) @(negedge clk_in);
        chk(cnt_a, ea);
        end_of_test();
    end
endmodule
